// ===== citd_opcode_class.sv
// Opcode classifier: byte length, base cycles, branch condition, target.
// Assumes the opcode is stable for the whole instruction.
`default_nettype none

module citd_opcode_class
  import citd_pkg::*;
(
  // Opcode
  input wire logic [7:0] opcode,
  // Classification
  output logic [1:0] cls_len,
  output logic [3:0] cls_cycles,
  output citd_cond_t cls_cond,
  output citd_tgt_t cls_target
);

  function automatic logic [12:0] pk(input logic [1:0] l,
                                     input logic [3:0] c,
                                     input citd_cond_t k,
                                     input citd_tgt_t t);
    pk = {l, c, k, t};
  endfunction

  logic [12:0] c;
  logic [12:0] one;
  logic [12:0] two;

  assign one = pk(LEN_ONE, CYC_ONE, COND_NONE, TGT_NONE);
  assign two = pk(LEN_TWO, CYC_TWO, COND_NONE, TGT_NONE);

  ////////////////////////////////////////////////////////////////////////
  // Opcode table, cycles counted in system clocks
  always_comb begin
    c = one;
    if (opcode[3]) begin
      case (opcode[7:4])
        4'h7, 4'h8, 4'hA: c = two;
        4'hB: c = pk(LEN_THREE, CYC_THREE, COND_UNEQUAL, TGT_REL);
        4'hD: c = pk(LEN_TWO, CYC_TWO, COND_NONZERO, TGT_REL);
        default: c = one;
      endcase
    end else if (opcode[3:1] == 3'b011) begin
      case (opcode[7:4])
        4'h7, 4'h8, 4'hA: c = two;
        4'hB: c = pk(LEN_THREE, CYC_FOUR, COND_UNEQUAL, TGT_REL);
        default: c = pk(LEN_ONE, CYC_TWO, COND_NONE, TGT_NONE);
      endcase
    end else begin
      case (opcode[2:0])
        3'h1: c = pk(LEN_TWO, CYC_THREE, COND_NONE, TGT_PAGE);
        3'h2: begin
          case (opcode[7:4])
            4'h0, 4'h1: c = pk(LEN_THREE, CYC_FOUR, COND_NONE, TGT_FULL);
            4'h2, 4'h3: c = pk(LEN_ONE, CYC_FIVE, COND_NONE, TGT_NONE);
            4'hE, 4'hF: c = pk(LEN_ONE, CYC_THREE, COND_NONE, TGT_NONE);
            default: c = two;
          endcase
        end
        3'h3: begin
          case (opcode[7:4])
            4'h4, 4'h5, 4'h6: c = pk(LEN_THREE, CYC_THREE, COND_NONE, TGT_NONE);
            4'h7: c = pk(LEN_ONE, CYC_THREE, COND_NONE, TGT_INDIRECT);
            4'h8, 4'h9, 4'hE, 4'hF: c = pk(LEN_ONE, CYC_THREE, COND_NONE,
                                          TGT_NONE);
            default: c = one;
          endcase
        end
        3'h4: begin
          case (opcode[7:4])
            4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: c = one;
            4'h8: c = pk(LEN_ONE, CYC_EIGHT, COND_NONE, TGT_NONE);
            4'hA: c = pk(LEN_ONE, CYC_FOUR, COND_NONE, TGT_NONE);
            4'hB: c = pk(LEN_THREE, CYC_THREE, COND_UNEQUAL, TGT_REL);
            default: c = two;
          endcase
        end
        3'h5: begin
          case (opcode[7:4])
            4'h7, 4'h8: c = pk(LEN_THREE, CYC_THREE, COND_NONE, TGT_NONE);
            4'hA: c = one;
            4'hB: c = pk(LEN_THREE, CYC_FOUR, COND_UNEQUAL, TGT_REL);
            4'hD: c = pk(LEN_THREE, CYC_THREE, COND_NONZERO, TGT_REL);
            default: c = two;
          endcase
        end
        default: begin
          case (opcode[7:4])
            4'h0: c = one;
            4'h1, 4'h2: c = pk(LEN_THREE, CYC_THREE, COND_BIT_SET, TGT_REL);
            4'h3: c = pk(LEN_THREE, CYC_THREE, COND_BIT_CLR, TGT_REL);
            4'h4: c = pk(LEN_TWO, CYC_TWO, COND_CARRY_SET, TGT_REL);
            4'h5: c = pk(LEN_TWO, CYC_TWO, COND_CARRY_CLR, TGT_REL);
            4'h6: c = pk(LEN_TWO, CYC_TWO, COND_ACC_ZERO, TGT_REL);
            4'h7: c = pk(LEN_TWO, CYC_TWO, COND_ACC_NZ, TGT_REL);
            4'h8: c = pk(LEN_TWO, CYC_THREE, COND_NONE, TGT_REL);
            4'h9: c = pk(LEN_THREE, CYC_THREE, COND_NONE, TGT_NONE);
            4'hE, 4'hF: c = pk(LEN_ONE, CYC_THREE, COND_NONE, TGT_NONE);
            default: c = two;
          endcase
        end
      endcase
    end
  end

  assign cls_len = c[12:11];
  assign cls_cycles = c[10:7];
  assign cls_cond = citd_cond_t'(c[6:3]);
  assign cls_target = citd_tgt_t'(c[2:0]);

endmodule // citd_opcode_class

`default_nettype wire

// ===== citd_pkg.sv
// Shared constants and types for the instruction timing decoder.
// Assumes a single system clock; all counts are in clock cycles.
`default_nettype none

package citd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Instruction length and cycle counts
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR = 4'h4;
  localparam logic [3:0] CYC_FIVE = 4'h5;
  localparam logic [3:0] CYC_EIGHT = 4'h8;
  localparam logic [3:0] CYC_FIRST = 4'h0;
  localparam logic [3:0] CYC_STEP = 4'h1;

  ////////////////////////////////////////////////////////////////////////
  // Opcodes and operand fields
  localparam logic [7:0] OPC_NO_OPERATION = 8'h00;
  localparam logic [7:0] OPC_SPARE = 8'hA5;
  localparam logic [7:0] OPC_BIT_TEST_CLEAR_JUMP = 8'h10;
  localparam logic [7:0] OPC_SHORT_RELATIVE_JUMP = 8'h80;
  localparam logic [7:0] SFR_BASE = 8'h80;
  localparam int unsigned PAGE_LSB = 11;
  localparam logic [15:0] ADDR_STEP_TWO = 16'h0002;

  ////////////////////////////////////////////////////////////////////////
  // Enumerations
  typedef enum logic [3:0] {
    COND_NONE, COND_CARRY_SET, COND_CARRY_CLR, COND_ACC_ZERO, COND_ACC_NZ,
    COND_BIT_SET, COND_BIT_CLR, COND_UNEQUAL, COND_NONZERO
  } citd_cond_t;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_REL, TGT_PAGE, TGT_FULL, TGT_INDIRECT
  } citd_tgt_t;

  typedef enum logic {ST_OPCODE, ST_BODY} citd_state_t;

endpackage

`default_nettype wire

// ===== citd_sequencer.sv
// Instruction timing sequencer: counts each instruction's clock cycles,
// captures operands, decides branches and issues transfer strobes.
// Assumes one instruction byte per clock on code_byte, next opcode
// presented the clock after instr_last; flags come from the same clock.
`default_nettype none

module citd_sequencer
  import citd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction byte stream
  input wire logic [7:0] code_byte,
  input wire logic [15:0] code_addr,
  // Datapath state
  input wire logic [1:0] bank_select,
  input wire logic carry_flag,
  input wire logic [7:0] acc_value,
  input wire logic [15:0] data_pointer,
  input wire logic tested_bit,
  input wire logic compare_unequal,
  input wire logic decrement_nonzero,
  // Sequencing
  output logic instr_start,
  output logic instr_last,
  output logic [3:0] cycle_index_r,
  output logic [7:0] opcode_r,
  output logic [1:0] byte_len_r,
  output logic [3:0] base_cycles_r,
  // Operands
  output logic [7:0] operand1_r,
  output logic [7:0] operand2_r,
  output logic [7:0] bank_register_operand_r,
  output logic [7:0] indirect_pointer_operand_r,
  output logic direct_is_sfr_r,
  output logic no_operation_r,
  // Control transfer
  output logic branch_taken,
  output logic transfer_go,
  output logic [15:0] jump_target_r,
  output logic bit_clear
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] reg_addr(input logic [1:0] bank,
                                          input logic [2:0] sel);
    reg_addr = {3'b000, bank, sel};
  endfunction

  function automatic logic is_sfr(input logic [7:0] addr);
    is_sfr = (addr >= SFR_BASE);
  endfunction

  citd_state_t state_r;
  logic ext_r;
  logic [15:0] instr_addr_r;
  logic [7:0] cur_op;
  logic [15:0] addr_view;
  logic [7:0] op1_view;
  logic [7:0] op2_view;
  logic [1:0] dec_len;
  logic [3:0] dec_cyc;
  citd_cond_t dec_cond;
  citd_tgt_t dec_tgt;
  logic at_base_end;
  logic at_len_end;
  logic cond_met;
  logic [15:0] calc_target;

  ////////////////////////////////////////////////////////////////////////
  // Current instruction view

  assign instr_start = (state_r == ST_OPCODE);
  assign cur_op = instr_start ? code_byte : opcode_r;
  assign addr_view = instr_start ? code_addr : instr_addr_r;
  assign op1_view = (cycle_index_r == 4'h1) ? code_byte : operand1_r;
  assign op2_view = (cycle_index_r == 4'h2) ? code_byte : operand2_r;

  citd_opcode_class u_class (
    .opcode(cur_op),
    .cls_len(dec_len),
    .cls_cycles(dec_cyc),
    .cls_cond(dec_cond),
    .cls_target(dec_tgt)
  );

  citd_target_calc u_target (
    .instr_addr(addr_view),
    .opcode(cur_op),
    .byte_len(dec_len),
    .kind(dec_tgt),
    .op1(op1_view),
    .op2(op2_view),
    .acc_value(acc_value),
    .data_pointer(data_pointer),
    .target(calc_target)
  );

  ////////////////////////////////////////////////////////////////////////
  // Branch decision

  always_comb begin
    case (dec_cond)
      COND_CARRY_SET: cond_met = carry_flag;
      COND_CARRY_CLR: cond_met = !carry_flag;
      COND_ACC_ZERO: cond_met = (acc_value == 8'h00);
      COND_ACC_NZ: cond_met = (acc_value != 8'h00);
      COND_BIT_SET: cond_met = tested_bit;
      COND_BIT_CLR: cond_met = !tested_bit;
      COND_UNEQUAL: cond_met = compare_unequal;
      COND_NONZERO: cond_met = decrement_nonzero;
      default: cond_met = 1'b0;
    endcase
  end

  assign at_base_end = !ext_r && (cycle_index_r == dec_cyc - CYC_STEP);
  assign at_len_end = !ext_r && (cycle_index_r == {2'b00, dec_len} - CYC_STEP);
  assign branch_taken = at_base_end && cond_met;
  assign instr_last = ext_r || (at_base_end && !cond_met);
  assign transfer_go = instr_last && (dec_tgt != TGT_NONE) &&
                       ((dec_cond == COND_NONE) || ext_r);
  assign bit_clear = instr_last && ext_r &&
                     (opcode_r == OPC_BIT_TEST_CLEAR_JUMP);

  ////////////////////////////////////////////////////////////////////////
  // Cycle counter and state

  always_ff @(posedge clk) begin
    if (reset) begin
      cycle_index_r <= CYC_FIRST;
    end else if (instr_last) begin
      cycle_index_r <= CYC_FIRST;
    end else begin
      cycle_index_r <= cycle_index_r + CYC_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_OPCODE;
    end else if (instr_last) begin
      state_r <= ST_OPCODE;
    end else begin
      state_r <= ST_BODY;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_r <= 1'b0;
    end else begin
      ext_r <= branch_taken;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Opcode capture

  always_ff @(posedge clk) begin
    if (reset) begin
      opcode_r <= OPC_NO_OPERATION;
      instr_addr_r <= 16'h0000;
      byte_len_r <= LEN_ONE;
      base_cycles_r <= CYC_ONE;
      no_operation_r <= 1'b1;
    end else if (instr_start) begin
      opcode_r <= code_byte;
      instr_addr_r <= code_addr;
      byte_len_r <= dec_len;
      base_cycles_r <= dec_cyc;
      no_operation_r <= (code_byte == OPC_NO_OPERATION) ||
                        (code_byte == OPC_SPARE);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bank_register_operand_r <= 8'h00;
      indirect_pointer_operand_r <= 8'h00;
    end else if (instr_start) begin
      bank_register_operand_r <= reg_addr(bank_select, code_byte[2:0]);
      indirect_pointer_operand_r <= reg_addr(bank_select,
                                             {2'b00, code_byte[0]});
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand capture

  always_ff @(posedge clk) begin
    if (reset) begin
      operand1_r <= 8'h00;
      direct_is_sfr_r <= 1'b0;
    end else if (cycle_index_r == 4'h1 && byte_len_r != LEN_ONE) begin
      operand1_r <= code_byte;
      direct_is_sfr_r <= is_sfr(code_byte);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      operand2_r <= 8'h00;
    end else if (cycle_index_r == 4'h2 && byte_len_r == LEN_THREE) begin
      operand2_r <= code_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      jump_target_r <= 16'h0000;
    end else if (at_len_end) begin
      jump_target_r <= calc_target;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [15:0] rel_expect;
  logic [15:0] page_next;

  assign page_next = instr_addr_r + ADDR_STEP_TWO;
  assign rel_expect = page_next + {{8{operand1_r[7]}}, operand1_r};

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (reset);

  sequence s_two;
    !instr_last ##1 instr_last;
  endsequence

  sequence s_three;
    !instr_last [*2] ##1 instr_last;
  endsequence

  sequence s_four;
    !instr_last [*3] ##1 instr_last;
  endsequence

  sequence s_five;
    !instr_last [*4] ##1 instr_last;
  endsequence

  property p_acc_single;
    instr_start && code_byte inside {8'hE4, 8'hF4, 8'h03, 8'h13, 8'h23,
                                     8'h33, 8'hC4} |-> instr_last;
  endproperty
  a_acc_single: assert property (p_acc_single)
    else $error("accumulator op not single cycle");

  property p_reg_moves;
    instr_start && code_byte[7:4] == 4'hE && code_byte[3] |-> instr_last;
  endproperty
  a_reg_moves: assert property (p_reg_moves)
    else $error("register move not single cycle");

  property p_ri_moves;
    instr_start && code_byte inside {8'hE6, 8'hE7, 8'hF6, 8'hF7} |-> s_two;
  endproperty
  a_ri_moves: assert property (p_ri_moves)
    else $error("indirect move not two cycles");

  property p_three_byte;
    instr_start && code_byte inside {8'h85, 8'h75, 8'h90} |->
      s_three ##0 byte_len_r == LEN_THREE;
  endproperty
  a_three_byte: assert property (p_three_byte)
    else $error("three byte move timing wrong");

  property p_one_byte_three;
    instr_start && code_byte inside {8'h83, 8'h93, 8'hE0, 8'hF0, 8'hE2,
                                     8'hE3, 8'hF2, 8'hF3} |->
      s_three ##0 byte_len_r == LEN_ONE;
  endproperty
  a_one_byte_three: assert property (p_one_byte_three)
    else $error("code or external move timing wrong");

  property p_stack_nibble;
    instr_start && code_byte inside {8'hC0, 8'hD0, 8'hD6, 8'hD7} |-> s_two;
  endproperty
  a_stack_nibble: assert property (p_stack_nibble)
    else $error("stack or nibble exchange timing wrong");

  property p_bit_ops;
    instr_start && code_byte inside {8'h72, 8'h82, 8'hA0, 8'hB0, 8'hC2}
      |-> s_two;
  endproperty
  a_bit_ops: assert property (p_bit_ops)
    else $error("direct bit op not two cycles");

  property p_taken_longer;
    branch_taken |-> !instr_last ##1 (instr_last && transfer_go);
  endproperty
  a_taken_longer: assert property (p_taken_longer)
    else $error("taken branch did not add one cycle");

  property p_flag_untaken;
    instr_start && code_byte inside {8'h40, 8'h50, 8'h60, 8'h70}
      ##1 !branch_taken |-> instr_last && !transfer_go;
  endproperty
  a_flag_untaken: assert property (p_flag_untaken)
    else $error("untaken flag jump not two cycles");

  property p_bit_clear;
    bit_clear |-> $past(branch_taken) && $past(tested_bit);
  endproperty
  a_bit_clear: assert property (p_bit_clear)
    else $error("bit cleared without taken test");

  property p_compare_long;
    instr_start && code_byte inside {8'hB5, 8'hB6, 8'hB7} |->
      !instr_last [*3] ##1 (instr_last || branch_taken);
  endproperty
  a_compare_long: assert property (p_compare_long)
    else $error("compare jump base not four cycles");

  property p_dec_reg;
    instr_start && code_byte[7:3] == 5'b11011 |->
      !instr_last ##1 (instr_last || branch_taken);
  endproperty
  a_dec_reg: assert property (p_dec_reg)
    else $error("register decrement jump base not two");

  property p_returns;
    instr_start && code_byte inside {8'h22, 8'h32} |-> s_five;
  endproperty
  a_returns: assert property (p_returns)
    else $error("return not five cycles");

  property p_long_transfer;
    instr_start && code_byte inside {8'h02, 8'h12} |->
      s_four ##0 transfer_go;
  endproperty
  a_long_transfer: assert property (p_long_transfer)
    else $error("long jump or call not four cycles");

  property p_rel_target;
    transfer_go && opcode_r == OPC_SHORT_RELATIVE_JUMP |->
      jump_target_r == rel_expect;
  endproperty
  a_rel_target: assert property (p_rel_target)
    else $error("relative target wrong");

  property p_page_target;
    transfer_go && dec_tgt == TGT_PAGE |->
      jump_target_r[15:PAGE_LSB] == page_next[15:PAGE_LSB];
  endproperty
  a_page_target: assert property (p_page_target)
    else $error("page local target left page");

  property p_sfr_split;
    cycle_index_r == 4'h1 && byte_len_r != LEN_ONE |=>
      direct_is_sfr_r == $past(code_byte[7]);
  endproperty
  a_sfr_split: assert property (p_sfr_split)
    else $error("direct address space split wrong");

  property p_spare_nop;
    instr_start && code_byte == OPC_SPARE |->
      instr_last ##1 (instr_start && no_operation_r);
  endproperty
  a_spare_nop: assert property (p_spare_nop)
    else $error("spare opcode not a no operation");

  property p_back_to_back;
    instr_last |=> instr_start && cycle_index_r == CYC_FIRST;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("gap after instruction");

endmodule // citd_sequencer

`default_nettype wire

// ===== citd_target_calc.sv
// Branch destination arithmetic for relative, page, full and indirect jumps.
// Assumes operand bytes are already visible when the result is used.
`default_nettype none

module citd_target_calc
  import citd_pkg::*;
(
  // Instruction context
  input wire logic [15:0] instr_addr,
  input wire logic [7:0] opcode,
  input wire logic [1:0] byte_len,
  input wire citd_tgt_t kind,
  // Operands
  input wire logic [7:0] op1,
  input wire logic [7:0] op2,
  input wire logic [7:0] acc_value,
  input wire logic [15:0] data_pointer,
  // Result
  output logic [15:0] target
);

  logic [15:0] next_addr;
  logic [7:0] rel_byte;

  assign next_addr = instr_addr + {14'h0000, byte_len};
  assign rel_byte = (byte_len == LEN_TWO) ? op1 : op2;

  always_comb begin
    case (kind)
      TGT_REL: target = next_addr + {{8{rel_byte[7]}}, rel_byte};
      TGT_PAGE: target = {next_addr[15:PAGE_LSB], opcode[7:5], op1};
      TGT_FULL: target = {op1, op2};
      TGT_INDIRECT: target = data_pointer + {8'h00, acc_value};
      default: target = next_addr;
    endcase
  end

endmodule // citd_target_calc

`default_nettype wire

// ===== test_citd_sequencer.sv
// Self-checking bench for the instruction timing sequencer.
// Assumes standard opcode encodings; bytes driven at the falling edge.
`default_nettype none

module test_citd_sequencer import citd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [7:0] op, b1, b2, bk, ip;
    logic [1:0] len;
    logic [3:0] base, cyc;
    logic go, clr;
    logic [15:0] tgt;
  } citd_note_t;

  // Opcode, byte length, untaken cycle count
  localparam logic [15:0] tbl [56] = '{
    16'hE411, 16'hF411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hC411,
    16'hE911, 16'hE612, 16'hF712, 16'h8533, 16'h7533, 16'hE522, 16'h9033,
    16'h9313, 16'h8313, 16'hE213, 16'hF313, 16'hE013, 16'hF013, 16'hC022,
    16'hD022, 16'hD612, 16'hC311, 16'hD311, 16'hB311, 16'hC222, 16'h8222,
    16'hB022, 16'h7222, 16'hA022, 16'h4022, 16'h5022, 16'h6022, 16'h7022,
    16'h2033, 16'h3033, 16'h1033, 16'hB534, 16'hB433, 16'hBB33, 16'hB634,
    16'hDA22, 16'hD533, 16'h1123, 16'h1234, 16'h2215, 16'h3215, 16'h0123,
    16'h0234, 16'h8023, 16'h7313, 16'h0011, 16'hA511, 16'hA414,
    16'h8418};

  logic clk = 0, reset = 1, carry_flag = 0, tested_bit = 0;
  logic compare_unequal = 0, decrement_nonzero = 0;
  logic [7:0] code_byte = 0, acc_value = 0;
  logic [15:0] code_addr = 0, data_pointer = 0;
  logic [1:0] bank_select = 0;
  logic instr_start, instr_last, branch_taken, transfer_go, bit_clear;
  logic direct_is_sfr_r, no_operation_r;
  logic [3:0] cycle_index_r, base_cycles_r;
  logic [7:0] opcode_r, operand1_r, operand2_r;
  logic [7:0] bank_register_operand_r, indirect_pointer_operand_r;
  logic [1:0] byte_len_r;
  logic [15:0] jump_target_r;
  int error_cnt = 0, samples_checked = 0, cnt = 0;
  integer seed = 32'h0000_70fe;
  citd_note_t notes[$], cur, prev, hd;
  bit have_prev = 0, want_start = 1;

  citd_sequencer dut_u (.clk, .reset, .code_byte, .code_addr, .bank_select,
    .carry_flag, .acc_value, .data_pointer, .tested_bit, .compare_unequal,
    .decrement_nonzero, .instr_start, .instr_last, .cycle_index_r,
    .opcode_r, .byte_len_r, .base_cycles_r, .operand1_r, .operand2_r,
    .bank_register_operand_r, .indirect_pointer_operand_r,
    .direct_is_sfr_r, .no_operation_r, .branch_taken, .transfer_go,
    .jump_target_r, .bit_clear);

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Returns {conditional, taken}
  function automatic logic [1:0] cond(input logic [7:0] op);
    case (op) inside
      8'h40: return {1'b1, carry_flag};
      8'h50: return {1'b1, !carry_flag};
      8'h60: return {1'b1, acc_value == 8'h00};
      8'h70: return {1'b1, acc_value != 8'h00};
      8'h20, 8'h10: return {1'b1, tested_bit};
      8'h30: return {1'b1, !tested_bit};
      [8'hB4:8'hBF]: return {1'b1, compare_unequal};
      8'hD5, [8'hD8:8'hDF]: return {1'b1, decrement_nonzero};
      default: return 2'b00;
    endcase
  endfunction

  task automatic run(input logic [15:0] ent);
    citd_note_t n;
    logic [1:0] k;
    logic [7:0] r;
    logic [15:0] nx;
    n.op = ent[15:8];
    n.len = ent[5:4];
    n.base = ent[3:0];
    if (n.op[3:0] == 4'h1) n.op[7:5] = 3'($random(seed));
    n.b1 = 8'($random(seed));
    n.b2 = 8'($random(seed));
    bank_select = 2'($random(seed));
    carry_flag = 1'($random(seed));
    tested_bit = 1'($random(seed));
    compare_unequal = 1'($random(seed));
    decrement_nonzero = 1'($random(seed));
    data_pointer = 16'($random(seed));
    acc_value = 8'($random(seed)) & {8{seed[3]}};
    code_addr = 16'($random(seed));
    // Page end, so the following address of a two or three byte instruction crosses into the next page
    if (seed[5]) code_addr[10:0] = 11'h7FE;
    k = cond(n.op);
    n.cyc = n.base + 4'(k[0]);
    r = (n.len == 2'h3) ? n.b2 : n.b1;
    nx = code_addr + 16'(n.len);
    n.go = !(k[1] && !k[0]);
    if (k[1] || n.op == OPC_SHORT_RELATIVE_JUMP) n.tgt = nx + {{8{r[7]}}, r};
    else if (n.op[3:0] == 4'h1) n.tgt = {nx[15:11], n.op[7:5], n.b1};
    else if (n.op inside {8'h02, 8'h12}) n.tgt = {n.b1, n.b2};
    else if (n.op == 8'h73) n.tgt = data_pointer + 16'(acc_value);
    else n.go = 0;
    n.clr = (n.op == OPC_BIT_TEST_CLEAR_JUMP) && k[0];
    n.bk = {3'h0, bank_select, n.op[2:0]};
    n.ip = {3'h0, bank_select, 2'h0, n.op[0]};
    notes.push_back(n);
    code_byte = n.op;
    for (int i = 0; i < 12; i++) begin
      #5;
      if (instr_last === 1'b1) break;
      @(negedge clk);
      code_byte = (i == 0) ? n.b1 : (i == 1) ? n.b2 : 8'($random(seed));
    end
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial forever #10 clk = ~clk;

  initial forever begin
    @(posedge clk);
    if (reset) begin
      have_prev = 0;
      want_start = 1;
    end else begin
      check(instr_start, want_start);
      want_start = (instr_last === 1'b1);
      if (instr_start === 1'b1) begin
        cnt = 0;
        if (have_prev) begin
          check(opcode_r, prev.op);
          check(no_operation_r, prev.op inside {8'h00, 8'hA5});
          check(byte_len_r, prev.len);
          check(base_cycles_r, prev.base);
          check(bank_register_operand_r, prev.bk);
          check(indirect_pointer_operand_r, prev.ip);
          if (prev.len > 2'h1) begin
            check(operand1_r, prev.b1);
            check(direct_is_sfr_r, prev.b1 >= SFR_BASE);
          end
          if (prev.len == 2'h3) check(operand2_r, prev.b2);
        end
      end
      cnt++;
      check(cycle_index_r, 16'(cnt - 1));
      if (notes.size() > 0) begin
        hd = notes[0];
        check(branch_taken, hd.cyc != hd.base && cnt == hd.base);
      end
      if (instr_last === 1'b1) begin
        cur = notes.pop_front();
        check(16'(cnt), cur.cyc);
        check(transfer_go, cur.go);
        check(bit_clear, cur.clr);
        if (cur.go) check(jump_target_r, cur.tgt);
        prev = cur;
        have_prev = 1;
      end
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    reset = 0;
    for (int p = 0; p < 4; p++)
      foreach (tbl[i]) run(tbl[i]);
    // Long instruction keeps the tail free of an unnoted end
    code_byte = 8'h90;
    @(posedge clk);
    #1;
    report_and_stop;
  end

  initial begin
    #200000;
    error_cnt++;
    report_and_stop;
  end
endmodule // test_citd_sequencer

`default_nettype wire
